// File: src/occ_clkctl.sv
// Contract
// - Signed 5-bit trim, zero is calibrated
// - 31 kHz from 8 MHz/256 or RC
// - PLL only at 4 or 8 MHz
// - PLL bit inert, reads zero, when unavailable
// - Trim register bit five reads zero
// - Select: 00 primary, 01 secondary, 1x internal
// - Every reset clears system clock select
// - Select write starts switch at once; here a write made during a switch waits until that switch ends
// - Glitch-free pause: two old, three new; here old edges are not waited on when the old source is not ready
// - Frequency select code table, 111 to 000
// - Frequency change takes effect immediately
// - Frequency select resets to 1 MHz
// - Watchdog always clocked by RC oscillator
// - Start-up flag shows primary ready
// - Internal stable flag when supplying clock
// - At most one source flag set
// - Sleep instruction enters idle or sleep
// - Secondary sleep ignored unless oscillator enabled
// - PLL needs internal primary config codes
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "occ_params.svh"
module occ_clkctl #(
    parameter int DIV_W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire occ_pkg::occ_pins_s pins,
    input wire logic [3:0] primary_osc_cfg,
    input wire logic two_speed_startup_cfg,
    input wire logic secondary_osc_enable,
    input wire logic sleep_exec,
    input wire logic wake,
    output logic sys_tick,
    output logic cpu_tick,
    output logic wdt_tick,
    output logic idle_mode,
    output logic sleep_mode,
    output logic pll_active,
    output logic internal_8mhz_source_enable,
    output logic signed [4:0] freq_trim,
    output occ_pkg::occ_flags_s flags
);
    localparam int NP = 7;
    localparam int P_PRI = 6;
    localparam int P_SEC = 5;
    localparam int P_INT = 4;
    localparam int P_LPRC = 3;
    localparam int P_PLL = 2;
    localparam int P_OST = 1;
    localparam int P_STB = 0;

    function automatic occ_pkg::occ_src_e src_of(input logic [1:0] sel);
        if (sel[1])
            return occ_pkg::SRC_INT;
        else if (sel[0])
            return occ_pkg::SRC_SEC;
        return occ_pkg::SRC_PRI;
    endfunction

    function automatic logic [DIV_W-1:0] freq_mask(input logic [2:0] f);
        logic [DIV_W-1:0] m;
        m = '0;
        unique case (f)
            3'h7: m = DIV_W'(8'h00);
            3'h6: m = DIV_W'(8'h01);
            3'h5: m = DIV_W'(8'h03);
            3'h4: m = DIV_W'(8'h07);
            3'h3: m = DIV_W'(8'h0F);
            3'h2: m = DIV_W'(8'h1F);
            3'h1: m = DIV_W'(8'h3F);
            3'h0: m = DIV_W'(8'hFF);
        endcase
        return m;
    endfunction

    // Source pins are asynchronous; a level counts once stages two and three agree
    logic [NP-1:0] pin_v;
    logic [NP-1:0] s1_r;
    logic [NP-1:0] s2_r;
    logic [NP-1:0] s3_r;
    logic [NP-1:0] filt_r;
    logic [NP-1:0] prev_r;
    logic [NP-1:0] rise;
    assign pin_v = pins;
    assign rise = filt_r & ~prev_r;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            s1_r <= pin_v;
            s2_r <= s1_r;
            s3_r <= s2_r;
            prev_r <= filt_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++)
        begin : g_filt
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                    filt_r[gi] <= 1'b0;
                else if (s2_r[gi] == s3_r[gi])
                    filt_r[gi] <= s3_r[gi];
            end
        end
    endgenerate

    // Registers
    logic lfsrc_r;
    logic pll_enable_bit_r;
    logic [4:0] trim_r;
    logic idle_r;
    logic [2:0] freq_r;
    logic [1:0] sel_r;
    logic pll_avail;
    logic [7:0] trim_rd;
    logic [7:0] ctrl_rd;
    logic wr_trim;
    logic wr_ctrl;
    assign wr_trim = reg_wr && reg_addr == `OCC_TRIM_OFS;
    assign wr_ctrl = reg_wr && reg_addr == `OCC_CTRL_OFS;
    assign pll_avail = primary_osc_cfg == `OCC_PLL_CFG_A || primary_osc_cfg == `OCC_PLL_CFG_B;
    assign freq_trim = $signed(trim_r);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            lfsrc_r <= 1'(`OCC_TRIM_RST >> `OCC_LFSRC_BIT);
            pll_enable_bit_r <= 1'b0;
            trim_r <= 5'h00;
        end
        else if (wr_trim)
        begin
            lfsrc_r <= reg_wdata[`OCC_LFSRC_BIT];
            pll_enable_bit_r <= reg_wdata[`OCC_PLL_ENABLE_BIT_BIT];
            trim_r <= reg_wdata[`OCC_TRIM_MSB:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            idle_r <= 1'b0;
            freq_r <= `OCC_FREQ_RST;
            sel_r <= `OCC_SEL_RST;
        end
        else if (wr_ctrl)
        begin
            idle_r <= reg_wdata[`OCC_IDLE_BIT];
            freq_r <= reg_wdata[`OCC_FREQ_LSB+:3];
            sel_r <= reg_wdata[`OCC_SEL_LSB+:2];
        end
    end

    // Unavailable PLL bit reads zero and is ignored; bit five always zero
    assign trim_rd = {lfsrc_r, pll_enable_bit_r & pll_avail, 1'b0, trim_r};
    assign ctrl_rd = {idle_r, freq_r, flags.primary_ready_flag, flags.internal_stable_flag, sel_r};

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `OCC_TRIM_OFS: reg_rdata <= trim_rd;
                `OCC_CTRL_OFS: reg_rdata <= ctrl_rd;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Internal block: postscaler and PLL path
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] mask;
    logic pll_on;
    logic lf_rc;
    logic int_tick;
    assign mask = freq_mask(freq_r);
    assign pll_on = pll_enable_bit_r && pll_avail && freq_r[2:1] == 2'b11;
    assign lf_rc = freq_r == `OCC_FREQ_31K && !lfsrc_r;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            div_r <= '0;
        else if (rise[P_INT])
            div_r <= div_r + 1'b1;
    end

    // Combinational mux so a frequency write acts on the next edge
    always_comb
    begin
        if (pll_on)
            int_tick = rise[P_PLL];
        else if (lf_rc)
            int_tick = rise[P_LPRC];
        else
            int_tick = rise[P_INT] && (div_r & mask) == mask;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pll_active <= 1'b0;
            internal_8mhz_source_enable <= 1'b0;
            wdt_tick <= 1'b0;
        end
        else
        begin
            pll_active <= pll_on;
            internal_8mhz_source_enable <= !lf_rc;
            wdt_tick <= rise[P_LPRC];
        end
    end

    // Clock switch
    occ_pkg::occ_sw_e sw_r;
    occ_pkg::occ_src_e act_r;
    occ_pkg::occ_src_e tgt_r;
    logic [1:0] cnt_r;
    logic old_edge;
    logic new_edge;
    logic old_ok;
    logic new_ok;

    function automatic logic edge_of(input occ_pkg::occ_src_e s, input logic [NP-1:0] r, input logic it);
        unique case (s)
            occ_pkg::SRC_PRI: return r[P_PRI];
            occ_pkg::SRC_SEC: return r[P_SEC];
            default: return it;
        endcase
    endfunction

    function automatic logic ready_of(input occ_pkg::occ_src_e s, input logic [NP-1:0] f, input logic sec, input logic rc);
        unique case (s)
            occ_pkg::SRC_PRI: return f[P_OST];
            occ_pkg::SRC_SEC: return sec;
            default: return f[P_STB] || rc;
        endcase
    endfunction

    assign old_edge = edge_of(act_r, rise, int_tick);
    assign new_edge = edge_of(tgt_r, rise, int_tick);
    assign old_ok = ready_of(act_r, filt_r, secondary_osc_enable, lf_rc);
    assign new_ok = ready_of(tgt_r, filt_r, secondary_osc_enable, lf_rc);

    // A dead old source would hang the switch, so it is not waited on
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sw_r <= occ_pkg::SW_RUN;
            act_r <= occ_pkg::SRC_PRI;
            tgt_r <= occ_pkg::SRC_PRI;
            cnt_r <= 2'h0;
        end
        else
        begin
            unique case (sw_r)
                occ_pkg::SW_RUN:
                begin
                    if (src_of(sel_r) != act_r)
                    begin
                        tgt_r <= src_of(sel_r);
                        sw_r <= occ_pkg::SW_OLD;
                        cnt_r <= 2'h0;
                    end
                end
                occ_pkg::SW_OLD:
                begin
                    if (old_edge || !old_ok)
                    begin
                        if (cnt_r == `OCC_OLD_EDGES - 2'h1 || !old_ok)
                        begin
                            sw_r <= occ_pkg::SW_NEW;
                            cnt_r <= 2'h0;
                        end
                        else
                            cnt_r <= cnt_r + 2'h1;
                    end
                end
                occ_pkg::SW_NEW:
                begin
                    if (new_edge && new_ok)
                    begin
                        if (cnt_r == `OCC_NEW_EDGES - 2'h1)
                        begin
                            act_r <= tgt_r;
                            sw_r <= occ_pkg::SW_RUN;
                            cnt_r <= 2'h0;
                        end
                        else
                            cnt_r <= cnt_r + 2'h1;
                    end
                end
                default:
                    sw_r <= occ_pkg::SW_RUN;
            endcase
        end
    end

    // Power modes
    logic sleep_ok;
    assign sleep_ok = !(sel_r == 2'b01 && !secondary_osc_enable);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            idle_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end
        else if (wake)
        begin
            idle_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end
        else if (sleep_exec && sleep_ok)
        begin
            idle_mode <= idle_r;
            sleep_mode <= !idle_r;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sys_tick <= 1'b0;
            cpu_tick <= 1'b0;
        end
        else
        begin
            sys_tick <= sw_r == occ_pkg::SW_RUN && old_edge && !sleep_mode;
            cpu_tick <= sw_r == occ_pkg::SW_RUN && old_edge && !sleep_mode && !idle_mode;
        end
    end

    // Start-up flag is caught from its strap on the first edge after release
    logic boot_r;
    logic run;
    assign run = sw_r == occ_pkg::SW_RUN;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            boot_r <= 1'b1;
            flags <= '0;
        end
        else
        begin
            boot_r <= 1'b0;
            if (boot_r)
                flags.primary_ready_flag <= !two_speed_startup_cfg;
            else
                flags.primary_ready_flag <= run && act_r == occ_pkg::SRC_PRI && filt_r[P_OST];
            flags.internal_stable_flag <= run && act_r == occ_pkg::SRC_INT && filt_r[P_STB] && !lf_rc;
            flags.secondary_running_flag <= run && act_r == occ_pkg::SRC_SEC;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_trim_bit5: assert property (reg_rd && reg_addr == `OCC_TRIM_OFS |=> !reg_rdata[5])
        else $error("trim bit five read nonzero");
    a_pll_readback: assert property (reg_rd && reg_addr == `OCC_TRIM_OFS && !pll_avail |=> !reg_rdata[6])
        else $error("unavailable pll bit read nonzero");
    a_pll_gate: assert property (pll_active |-> $past(pll_enable_bit_r && pll_avail && freq_r[2:1] == 2'b11))
        else $error("pll active outside allowed setting");
    a_boot_values: assert property (boot_r |-> sel_r == 2'b00 && freq_r == 3'h4)
        else $error("select or frequency wrong after reset");
    a_switch_start: assert property (run && src_of(sel_r) != act_r |=> sw_r == occ_pkg::SW_OLD)
        else $error("select change did not start switch");
    a_pause_quiet: assert property (!run |=> !sys_tick)
        else $error("tick during clock switch");
    a_new_count: assert property (sw_r == occ_pkg::SW_NEW && cnt_r == 2'h2 && new_edge && new_ok |=> run && act_r == $past(tgt_r))
        else $error("switch did not end after three new edges");
    a_flags_onehot: assert property ($onehot0(flags))
        else $error("more than one source flag set");
    a_sleep_mode: assert property (sleep_exec && sleep_ok && !wake |=> idle_mode == $past(idle_r) && sleep_mode != idle_mode)
        else $error("sleep instruction gave wrong mode");
    a_sec_ignore: assert property (sleep_exec && !sleep_ok && !wake |=> $stable(idle_mode) && $stable(sleep_mode))
        else $error("secondary sleep not ignored");
    a_wdt_rc: assert property (rise[P_LPRC] |=> wdt_tick)
        else $error("watchdog tick missed rc edge");
    a_lf_rc: assert property (pll_on == 1'b0 && lf_rc |-> int_tick == rise[P_LPRC])
        else $error("31 kHz not from rc");

    c_switch_done: cover property (sw_r == occ_pkg::SW_NEW ##1 run);
    c_sleep: cover property (sleep_exec && sleep_ok && !idle_r);
    c_pll: cover property (pll_active && run && act_r == occ_pkg::SRC_INT);
endmodule
`default_nettype wire

// File: src/occ_params.svh
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH
`define OCC_TRIM_OFS 2'h0
`define OCC_CTRL_OFS 2'h1
`define OCC_LFSRC_BIT 7
`define OCC_PLL_ENABLE_BIT_BIT 6
`define OCC_TRIM_MSB 4
`define OCC_IDLE_BIT 7
`define OCC_FREQ_LSB 4
`define OCC_PRIMARY_READY_FLAG_BIT 3
`define OCC_INTERNAL_STABLE_FLAG_BIT 2
`define OCC_SEL_LSB 0
`define OCC_TRIM_RST 8'h00
`define OCC_FREQ_RST 3'h4
`define OCC_SEL_RST 2'h0
`define OCC_FREQ_31K 3'h0
`define OCC_PLL_CFG_A 4'h9
`define OCC_PLL_CFG_B 4'h8
`define OCC_OLD_EDGES 2'h2
`define OCC_NEW_EDGES 2'h3
`endif

// File: src/occ_pkg.sv
`default_nettype none
package occ_pkg;
    typedef enum logic [1:0] {
        SRC_PRI = 2'b00,
        SRC_SEC = 2'b01,
        SRC_INT = 2'b10
    } occ_src_e;
    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_OLD = 2'b01,
        SW_NEW = 2'b10
    } occ_sw_e;
    typedef struct packed {
        logic primary_clk;
        logic secondary_clk;
        logic internal_8mhz_source_clk;
        logic lprc_clk;
        logic pll_clk;
        logic ost_done;
        logic internal_8mhz_source_stable;
    } occ_pins_s;
    typedef struct packed {
        logic primary_ready_flag;
        logic internal_stable_flag;
        logic secondary_running_flag;
    } occ_flags_s;
endpackage
`default_nettype wire

// File: src/occ_extra_unused_none.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: test/occ_clkctl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module occ_clkctl_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    occ_pkg::occ_pins_s pins;
    logic [3:0] cfg = 4'h0;
    logic sec_en = 1'b0;
    logic tss = 1'b0;
    logic sleep_exec = 1'b0;
    logic wake = 1'b0;
    logic sys_tick, cpu_tick, wdt_tick, idle_mode, sleep_mode, pll_active, internal_8mhz_source_enable;
    logic signed [4:0] freq_trim;
    occ_pkg::occ_flags_s flags;
    logic [7:0] pc = 8'h00;
    logic [7:0] q;
    int num_errors = 0;
    int num_checks = 0;
    int ns = 0;
    int nc = 0;
    int nw = 0;
    int a;

    occ_clkctl uut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .primary_osc_cfg(cfg),
        .two_speed_startup_cfg(tss), .secondary_osc_enable(sec_en), .sleep_exec(sleep_exec),
        .wake(wake), .sys_tick(sys_tick), .cpu_tick(cpu_tick), .wdt_tick(wdt_tick),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode), .pll_active(pll_active),
        .internal_8mhz_source_enable(internal_8mhz_source_enable), .freq_trim(freq_trim), .flags(flags)
    );

    always #5 mclk = ~mclk;

    // Source clocks are slow against mclk so the pin synchronisers never drop an edge
    always @(posedge mclk) pc <= pc + 8'h01;
    assign pins = {pc[2], pc[4], pc[3], pc[5], pc[2], 1'b1, 1'b1};

    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    always @(posedge mclk)
    begin
        ns <= ns + int'(sys_tick);
        nc <= nc + int'(cpu_tick);
        nw <= nw + int'(wdt_tick);
        if (!rst)
            chk({7'h0, $countones(flags) <= 1}, 8'h01, "flags onehot");
    end

    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task wr(input logic [1:0] ad, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // Let the stored value settle before anyone looks at outputs
        #1;
    endtask

    task rd(input logic [1:0] ad);
        @(posedge mclk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task win(input int n);
        @(posedge mclk);
        #1;
        ns = 0;
        nc = 0;
        nw = 0;
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task pulse(input bit w);
        @(posedge mclk);
        if (w)
            wake <= 1'b1;
        else
            sleep_exec <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        sleep_exec <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task wfl(input int k);
        int i;
        logic f;
        f = 1'b0;
        // A 31 kHz old source needs two slow edges, several thousand cycles
        for (i = 0; i < 12000 && f !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
            f = (k == 0) ? flags.primary_ready_flag : (k == 1) ? flags.internal_stable_flag
                : flags.secondary_running_flag;
        end
        if (f !== 1'b1)
        begin
            num_errors++;
            $display("mismatch t=%0t source flag %0d never set", $time, k);
            report_and_stop;
        end
    endtask

    task settle;
        repeat (10) @(posedge mclk);
        #1;
    endtask

    initial
    begin
        #1000000;
        num_errors++;
        $display("mismatch t=%0t run too long", $time);
        report_and_stop;
    end

    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk({7'h0, flags.primary_ready_flag}, 8'h01, "startup flag strap low");
        rd(2'h0);
        chk(q, 8'h00, "trim reset");
        rd(2'h1);
        chk(q & 8'hF3, 8'h40, "control reset");
        $display("test reset done");
        // Trim field with no PLL configuration: PLL bit and bit five stay zero
        wr(2'h0, 8'hFF);
        rd(2'h0);
        chk(q, 8'h9F, "trim readback");
        chk({3'h0, freq_trim}, 8'h1F, "trim minus one");
        wr(2'h0, 8'h0F);
        chk({3'h0, freq_trim}, 8'h0F, "trim max");
        wr(2'h0, 8'h10);
        chk({3'h0, freq_trim}, 8'h10, "trim min");
        wr(2'h2, 8'hFF);
        rd(2'h2);
        chk(q, 8'h00, "unmapped 2");
        rd(2'h3);
        chk(q, 8'h00, "unmapped 3");
        rd(2'h0);
        chk(q, 8'h10, "trim untouched");
        $display("test trim done");
        wr(2'h1, 8'h72);
        wfl(1);
        rd(2'h1);
        chk(q & 8'hF7, 8'h76, "internal active");
        win(512);
        a = ns;
        wr(2'h1, 8'h62);
        win(512);
        chk({7'h0, (a >= 2 * ns - 2) && (a <= 2 * ns + 2)}, 8'h01, "rate halves");
        $display("test internal done");
        cfg <= 4'h9;
        wr(2'h0, 8'h40);
        rd(2'h0);
        chk(q, 8'h40, "pll bit kept");
        wr(2'h1, 8'h72);
        settle;
        chk({7'h0, pll_active}, 8'h01, "pll at 8M");
        wr(2'h1, 8'h52);
        settle;
        chk({7'h0, pll_active}, 8'h00, "pll at 2M");
        wr(2'h1, 8'h62);
        cfg <= 4'h8;
        settle;
        chk({7'h0, pll_active}, 8'h01, "pll at 4M");
        cfg <= 4'h0;
        settle;
        chk({7'h0, pll_active}, 8'h00, "pll cfg off");
        rd(2'h0);
        chk(q & 8'h40, 8'h00, "pll bit reads 0");
        $display("test pll done");
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h02);
        settle;
        chk({7'h0, internal_8mhz_source_enable}, 8'h00, "31k from rc");
        wr(2'h0, 8'h80);
        settle;
        chk({7'h0, internal_8mhz_source_enable}, 8'h01, "31k from div");
        $display("test low freq done");
        sec_en <= 1'b1;
        wr(2'h1, 8'h01);
        wfl(2);
        sec_en <= 1'b0;
        pulse(1'b0);
        chk({6'h0, idle_mode, sleep_mode}, 8'h00, "sleep ignored");
        sec_en <= 1'b1;
        wr(2'h1, 8'h00);
        wfl(0);
        $display("test secondary done");
        wr(2'h1, 8'h80);
        pulse(1'b0);
        chk({6'h0, idle_mode, sleep_mode}, 8'h02, "idle entered");
        win(200);
        chk({7'h0, nc == 0 && ns > 0}, 8'h01, "idle ticks");
        pulse(1'b1);
        wr(2'h1, 8'h00);
        pulse(1'b0);
        chk({6'h0, idle_mode, sleep_mode}, 8'h01, "sleep entered");
        win(200);
        chk({7'h0, ns == 0 && nw > 0}, 8'h01, "sleep ticks");
        pulse(1'b1);
        chk({6'h0, idle_mode, sleep_mode}, 8'h00, "woken");
        $display("test sleep done");
        wr(2'h1, 8'h72);
        @(posedge mclk);
        rst <= 1'b1;
        tss <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk({7'h0, flags.primary_ready_flag}, 8'h00, "startup flag strap high");
        rd(2'h1);
        chk(q & 8'hF3, 8'h40, "control after reset");
        rd(2'h0);
        chk(q, 8'h00, "trim after reset");
        $display("test second reset done");
        report_and_stop;
    end
endmodule
`default_nettype wire
